// [hw/scsp_port.sv]
// SMBus slave port with configuration registers and status pin routing

// Notes on behaviour
// - Slave answers and registers are reachable only while the mode strap is high.
// - Select inputs all low gives slave address 1010000, write byte A0h.
// - Select inputs form the low four bits of the slave address.
// - Data falling while clock high is a start.
// - Data rising while clock high is a stop.
// - Both lines high past free time after stop, or max high time, means idle.
// - Driven data stays stable while the clock is high, except start and stop.
// - Write: start, address+0, register, data, stop; each byte acknowledged low.
// - After acknowledging read address, device sends register byte MSB first.
// - Writing 01h to register 00h restores every register default.
// - Writing 0Fh to the eight swing registers selects 1.0 V swing.
// - Writing 39h to B-side equalization registers selects the pin-10 level.
// - Writing A0h to A-side de-emphasis registers selects enhanced -12 dB.
// - Bit 0 of 4Eh turns select pins into status outputs.
// - Bits 5:4 of 47h route idle status; 32h gives pairwise OR.
// - Enabled status blocks sharing a pin are combined by OR.
// - Idle status is high for electrical idle, low for active data.
// - Bits 7:6 of 4Ch route rate status with the same grouping.
// - Rate status is high for high rate, low for low rate.
// - Clock held low beyond the timeout resets the serial interface.
// - Max clock-high is 50 us, bus free time 4.7 us.
module scsp_port
  import scsp_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
)
(
  // System clock and reset
  input  wire logic     ref_clk,
  input  wire logic     reset_n,
  // SMBus link, clock port and open-drain data
  input  wire logic     sclClk,
  input  wire logic     sdaIn,
  output logic          sdaOut,
  output logic          sdaOeN,
  // Straps and shared select/status pins
  input  wire logic     mgmtModeStrap,
  input  wire logic [3:0] gpioIn,
  output logic [3:0]    gpioOut,
  output logic [3:0]    gpioOeN,
  // Analog side
  input  scsp_status_t  chStatus,
  output scsp_settings_t settings,
  output logic          busIdle
);

  localparam int SYN_W = 24;

  // Refuse a timeout that the low-time counter cannot reach
  if (TIMEOUT_CYCLES < 1 || TIMEOUT_CYCLES > (2 ** TIMER_W) - 1)
  begin : gBadTimeout
    $error("TIMEOUT_CYCLES out of range");
  end

  logic               linkBit_r;
  logic               linkTog_r;
  logic [SYN_W-1:0]   syncIn;
  logic [SYN_W-1:0]   syncA_r;
  logic [SYN_W-1:0]   syncB_r;
  logic [2:0]         prev_r;
  logic               sclS;
  logic               sdaS;
  logic               modeS;
  logic [3:0]         adS;
  scsp_status_t       statS;
  logic               togS;
  logic               startEvt;
  logic               stopEvt;
  logic               sclFall;
  logic               bitEvt;
  logic               timeoutEvt;
  logic               idleEvt;
  logic [TIMER_W-1:0] lowCnt_r;
  logic [10:0]        highCnt_r;
  logic               stopSeen_r;
  logic               busIdle_r;
  scsp_state_t        state_r;
  logic [7:0]         shift_r;
  logic [7:0]         rxByte;
  logic [2:0]         bitCnt_r;
  logic [1:0]         ackStep_r;
  logic [7:0]         ptr_r;
  logic               wrPend_r;
  logic               wrStb_r;
  logic [7:0]         wrData_r;
  logic [7:0]         txShift_r;
  logic [3:0]         rdCnt_r;
  logic               sdaOeN_r;
  logic [7:0]         rdData;
  logic [7:0]         regs_r [NUM_REGS];
  logic [3:0]         adLatch_r;
  logic [6:0]         slaveAddr;
  logic [3:0]         gpioOut_r;
  logic               pinEn;

  // Link domain: capture data on each rising clock edge, flag it by toggle
  always_ff @(posedge sclClk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      linkBit_r <= 1'b0;
      linkTog_r <= 1'b0;
    end
    else
    begin
      linkBit_r <= sdaIn;
      linkTog_r <= ~linkTog_r;
    end
  end

  // Two-flop synchronisers for pins and the link toggle
  assign syncIn = {linkTog_r, chStatus, gpioIn, mgmtModeStrap, sdaIn, sclClk};

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      // Lines seen high; toggle copy matches the link flop's reset level
      syncA_r <= {1'b0, {(SYN_W-1){1'b1}}};
      syncB_r <= {1'b0, {(SYN_W-1){1'b1}}};
    end
    else
    begin
      syncA_r <= syncIn;
      syncB_r <= syncA_r;
    end
  end

  assign sclS  = syncB_r[0];
  assign sdaS  = syncB_r[1];
  assign modeS = syncB_r[2];
  assign adS   = syncB_r[6:3];
  assign statS = syncB_r[22:7];
  assign togS  = syncB_r[23];

  // Previous synchronised levels for edge detection
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      prev_r <= 3'h3;   // No false bit event after reset
    else
      prev_r <= {togS, sdaS, sclS};
  end

  // Line events
  assign startEvt = sclS & prev_r[0] & prev_r[1] & ~sdaS;
  assign stopEvt  = sclS & prev_r[0] & ~prev_r[1] & sdaS;
  assign sclFall  = prev_r[0] & ~sclS;
  assign bitEvt   = togS ^ prev_r[2];   // Data bit held stable while high
  assign timeoutEvt = ~sclS &
                      (lowCnt_r == TIMER_W'(TIMEOUT_CYCLES - 1));
  assign idleEvt  = ~busIdle_r & sclS & sdaS &
                    ((stopSeen_r & (highCnt_r >= 11'(TBUF_CYC))) |
                     (highCnt_r >= 11'(THIGH_CYC)));

  // Clock-low timer, saturating
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      lowCnt_r <= '0;
    else if (sclS)
      lowCnt_r <= '0;
    else if (lowCnt_r != TIMER_W'(TIMEOUT_CYCLES))
      lowCnt_r <= lowCnt_r + TIMER_W'(1);
  end

  // Both-lines-high timer and bus idle flag
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      highCnt_r  <= '0;
      stopSeen_r <= 1'b0;
      busIdle_r  <= 1'b0;
    end
    else
    begin
      if (!(sclS && sdaS))
        highCnt_r <= '0;
      else if (highCnt_r != 11'(THIGH_CYC))
        highCnt_r <= highCnt_r + 11'h001;
      if (stopEvt)
        stopSeen_r <= 1'b1;
      else if (startEvt)
        stopSeen_r <= 1'b0;
      if (startEvt)
        busIdle_r <= 1'b0;
      else if (idleEvt)
        busIdle_r <= 1'b1;
    end
  end

  // Address compare inputs
  assign slaveAddr = ADDR_BASE | {3'h0, adLatch_r};
  assign rxByte    = {shift_r[6:0], linkBit_r};

  // Protocol engine
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r   <= ST_IDLE;
      shift_r   <= '0;
      bitCnt_r  <= '0;
      ackStep_r <= '0;
      ptr_r     <= '0;
      wrPend_r  <= 1'b0;
      wrStb_r   <= 1'b0;
      wrData_r  <= '0;
      txShift_r <= '0;
      rdCnt_r   <= '0;
      sdaOeN_r  <= 1'b1;
    end
    else
    begin
      wrStb_r <= 1'b0;
      if (stopEvt || timeoutEvt || idleEvt)
      begin
        state_r   <= ST_IDLE;
        ackStep_r <= '0;
        wrPend_r  <= 1'b0;
        sdaOeN_r  <= 1'b1;
      end
      else if (startEvt)
      begin
        state_r   <= ST_ADDR;   // Start and repeated start
        bitCnt_r  <= '0;
        ackStep_r <= '0;
        wrPend_r  <= 1'b0;
        rdCnt_r   <= '0;
        sdaOeN_r  <= 1'b1;
      end
      else if (ackStep_r != 2'h0)
      begin
        // Acknowledge slot: drive low after the fall; after the next, release, or in a read put out the MSB
        case (ackStep_r)
          2'h1:
            if (sclFall)
            begin
              sdaOeN_r  <= 1'b0;
              ackStep_r <= 2'h2;
            end
          2'h2:
            if (bitEvt)
            begin
              ackStep_r <= 2'h3;
              wrStb_r   <= wrPend_r;
              wrPend_r  <= 1'b0;
            end
          default:
            if (sclFall)
            begin
              ackStep_r <= 2'h0;
              if (state_r == ST_RDATA)
              begin
                sdaOeN_r  <= rdData[7];
                txShift_r <= {rdData[6:0], 1'b0};
                rdCnt_r   <= 4'h1;
              end
              else
                sdaOeN_r <= 1'b1;
            end
        endcase
      end
      else
      begin
        case (state_r)
          ST_ADDR, ST_REG, ST_WDATA:
            if (bitEvt)
            begin
              shift_r  <= rxByte;
              bitCnt_r <= bitCnt_r + 3'h1;
              if (bitCnt_r == 3'h7)
              begin
                if (state_r == ST_ADDR)
                begin
                  if (modeS && rxByte[7:1] == slaveAddr)
                  begin
                    ackStep_r <= 2'h1;
                    state_r   <= rxByte[0] ? ST_RDATA : ST_REG;
                  end
                  else
                    state_r <= ST_IGNORE;
                end
                else if (state_r == ST_REG)
                begin
                  ptr_r     <= rxByte;
                  ackStep_r <= 2'h1;
                  state_r   <= ST_WDATA;
                end
                else
                begin
                  wrData_r  <= rxByte;
                  wrPend_r  <= 1'b1;
                  ackStep_r <= 2'h1;
                end
              end
            end
          ST_RDATA:
            if (sclFall && rdCnt_r < 4'h8)
            begin
              sdaOeN_r  <= txShift_r[7];   // MSB first
              txShift_r <= {txShift_r[6:0], 1'b0};
              rdCnt_r   <= rdCnt_r + 4'h1;
            end
            else if (sclFall && rdCnt_r == 4'h8)
            begin
              sdaOeN_r <= 1'b1;   // Release for the host's answer
              rdCnt_r  <= 4'h9;
            end
            else if (bitEvt && rdCnt_r == 4'h9)
            begin
              if (linkBit_r)
                state_r <= ST_IGNORE;   // Not-acknowledge ends the read
              else
              begin
                txShift_r <= rdData;
                rdCnt_r   <= 4'h0;
              end
            end
          ST_IDLE, ST_IGNORE:
            sdaOeN_r <= 1'b1;
          default:
            state_r <= ST_IDLE;
        endcase
      end
    end
  end

  // Read multiplexer; unmapped offsets read as zero
  always_comb
  begin
    rdData = 8'h00;
    for (int i = 0; i < NUM_REGS; i++)
      if (ptr_r == REG_OFS[i])
        rdData = regs_r[i];
  end

  // Register file, one entry per documented offset
  for (genvar i = 0; i < NUM_REGS; i++)
  begin : gReg
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
      if (!reset_n)
        regs_r[i] <= REG_DEF[i];
      else if (wrStb_r && ptr_r == OFS_RESET && wrData_r == RESET_CMD)
        regs_r[i] <= REG_DEF[i];
      else if (wrStb_r && ptr_r == REG_OFS[i])
        regs_r[i] <= wrData_r;
    end
  end

  // Settings to the analog drivers and equalizers
  for (genvar j = 0; j < 8; j++)
  begin : gSwing
    assign settings.swing[j] = regs_r[SWING_IDX[j]];
  end
  for (genvar j = 0; j < 4; j++)
  begin : gEqDe
    assign settings.eq[j]     = regs_r[EQ_IDX[j]];
    assign settings.deemph[j] = regs_r[DEEMPH_IDX[j]];
  end

  assign pinEn = regs_r[IDX_PIN_EN][PIN_EN_BIT];

  // Address select latch, frozen once the pins become outputs
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      adLatch_r <= 4'h0;
    else if (!pinEn)
      adLatch_r <= adS;
  end

  // Status pin values: enabled blocks per pin are ORed
  for (genvar k = 0; k < NUM_PINS; k++)
  begin : gPin
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
      if (!reset_n)
        gpioOut_r[k] <= 1'b0;
      else
        gpioOut_r[k] <=
          (regs_r[IDX_IDLE_ROUTE][IDLE_LO_BIT] & statS.idle[PIN_CH_LO[k]]) |
          (regs_r[IDX_IDLE_ROUTE][IDLE_HI_BIT] & statS.idle[PIN_CH_HI[k]]) |
          (regs_r[IDX_RATE_ROUTE][RATE_LO_BIT] & statS.rate[PIN_CH_LO[k]]) |
          (regs_r[IDX_RATE_ROUTE][RATE_HI_BIT] & statS.rate[PIN_CH_HI[k]]);
    end
  end

  // Outputs
  assign gpioOut = gpioOut_r;
  assign gpioOeN = {NUM_PINS{~pinEn}};
  assign sdaOut  = 1'b0;                 // Open drain: only ever pulls low
  assign sdaOeN  = sdaOeN_r;
  assign busIdle = busIdle_r;

endmodule : scsp_port

// [hw/scsp_pkg.sv]
// Constants and types for the SMBus configuration and status port
package scsp_pkg;

  // Reference clock and bus timing
  localparam int REF_CLK_HZ    = 25_000_000;
  localparam int CYC_PER_US    = REF_CLK_HZ / 1_000_000;
  localparam int TBUF_NS       = 4700;  // Bus free time after a stop
  localparam int THIGH_MAX_NS  = 50000; // Longest clock-high period
  localparam int TIMEOUT_MS    = 25;    // Clock-low detect timeout
  localparam int TBUF_CYC      = (TBUF_NS * CYC_PER_US + 999) / 1000;
  localparam int THIGH_CYC     = (THIGH_MAX_NS * CYC_PER_US) / 1000;
  localparam int TIMEOUT_CYC   = TIMEOUT_MS * (REF_CLK_HZ / 1000);
  localparam int TIMER_W       = 20;

  // Slave address: base, low four bits from the select inputs
  localparam logic [6:0] ADDR_BASE = 7'h50;

  // Register file layout, in order of offset
  localparam int NUM_REGS = 20;
  localparam logic [7:0] REG_OFS [NUM_REGS] = '{
    8'h00, 8'h0F, 8'h10, 8'h16, 8'h17, 8'h1D, 8'h1E, 8'h24, 8'h25, 8'h2D,
    8'h2E, 8'h34, 8'h35, 8'h3B, 8'h3C, 8'h42, 8'h43, 8'h47, 8'h4C, 8'h4E};
  localparam logic [7:0] REG_DEF [NUM_REGS] = '{
    8'h00, 8'h20, 8'h00, 8'h20, 8'h00, 8'h20, 8'h00, 8'h20, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam int SWING_IDX  [8] = '{2, 4, 6, 8, 9, 11, 13, 15};
  localparam int EQ_IDX     [4] = '{1, 3, 5, 7};
  localparam int DEEMPH_IDX [4] = '{10, 12, 14, 16};
  localparam int IDX_IDLE_ROUTE = 17;
  localparam int IDX_RATE_ROUTE = 18;
  localparam int IDX_PIN_EN     = 19;

  // Register reset command
  localparam logic [7:0] OFS_RESET = 8'h00;
  localparam logic [7:0] RESET_CMD = 8'h01;

  // Field positions
  localparam int PIN_EN_BIT   = 0;
  localparam int IDLE_LO_BIT  = 4;
  localparam int IDLE_HI_BIT  = 5;
  localparam int RATE_LO_BIT  = 6;
  localparam int RATE_HI_BIT  = 7;

  // Channels combined onto each status pin
  localparam int NUM_PINS = 4;
  localparam int PIN_CH_LO [NUM_PINS] = '{0, 1, 4, 5};
  localparam int PIN_CH_HI [NUM_PINS] = '{2, 3, 6, 7};

  // Protocol engine states
  typedef enum logic [5:0] {
    ST_IDLE   = 6'b000001,
    ST_ADDR   = 6'b000010,
    ST_REG    = 6'b000100,
    ST_WDATA  = 6'b001000,
    ST_RDATA  = 6'b010000,
    ST_IGNORE = 6'b100000
  } scsp_state_t;

  // Per-channel detector status from the analog side
  typedef struct packed {
    logic [7:0] rate;
    logic [7:0] idle;
  } scsp_status_t;

  // Settings handed to the analog side
  typedef struct packed {
    logic [7:0][7:0] swing;
    logic [3:0][7:0] eq;
    logic [3:0][7:0] deemph;
  } scsp_settings_t;

endpackage : scsp_pkg

// [verif/scsp_port_asserts.sv]
// Concurrent checks on the pins of the SMBus configuration port
module scsp_port_asserts
  import scsp_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
)
(
  // Clock, reset and link
  input wire logic           ref_clk,
  input wire logic           reset_n,
  input wire logic           sclClk,
  input wire logic           sdaIn,
  input wire logic           sdaOut,
  input wire logic           sdaOeN,
  // Straps, pins and analog side
  input wire logic           mgmtModeStrap,
  input wire logic [3:0]     gpioIn,
  input wire logic [3:0]     gpioOut,
  input wire logic [3:0]     gpioOeN,
  input wire scsp_status_t   chStatus,
  input wire scsp_settings_t settings,
  input wire logic           busIdle
);
  int   lowCnt_r;
  int   highCnt_r;
  logic stopSeen_r;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Cycles with clock low, and with both lines high
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
    begin
      lowCnt_r  <= 0;
      highCnt_r <= 0;
    end
    else
    begin
      lowCnt_r  <= sclClk ? 0 : lowCnt_r + 1;
      highCnt_r <= (sclClk && sdaIn) ? highCnt_r + 1 : 0;
    end
  // Remembers a stop until the next start
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
      stopSeen_r <= 1'b0;
    else if (sclClk && $past(sclClk) && $changed(sdaIn))
      stopSeen_r <= sdaIn;
  sequence startSeq;
    sclClk && $past(sclClk) && $fell(sdaIn);
  endsequence
  sequence quietSeq;
    (chStatus == '0) [*5];
  endsequence
  AST_STRAP_OFF: assert property ((!mgmtModeStrap) [*8] |-> sdaOeN)
    else $error("data driven with strap low");
  AST_START_BUSY: assert property (startSeq |-> ##[1:5] !busIdle)
    else $error("start left bus idle");
  AST_STOP_IDLE: assert property (stopSeen_r && highCnt_r == 124 |-> busIdle)
    else $error("no idle after stop");
  AST_HIGH_IDLE: assert property (highCnt_r == 1256 |-> busIdle)
    else $error("no idle after long high");
  AST_IDLE_CAUSE: assert property ($rose(busIdle) |-> $past(sclClk && sdaIn))
    else $error("idle without both lines high");
  AST_SDA_STABLE: assert property (sclClk && $past(sclClk) |-> $stable(sdaOeN))
    else $error("data moved while clock high");
  AST_DRIVE_LOW: assert property ($fell(sdaOeN) |-> !sclClk)
    else $error("drive began with clock high");
  AST_TIMEOUT: assert property (lowCnt_r == TIMEOUT_CYCLES + 8 |-> sdaOeN)
    else $error("data held after clock timeout");
  AST_QUIET_PINS: assert property (quietSeq |-> gpioOut == 4'h0)
    else $error("status pin high without cause");
  AST_PIN_MODE: assert property (gpioOeN inside {4'h0, 4'hF})
    else $error("status pins split in mode");
endmodule : scsp_port_asserts

bind scsp_port scsp_port_asserts #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk (
  .ref_clk(ref_clk), .reset_n(reset_n), .sclClk(sclClk), .sdaIn(sdaIn),
  .sdaOut(sdaOut), .sdaOeN(sdaOeN), .mgmtModeStrap(mgmtModeStrap),
  .gpioIn(gpioIn), .gpioOut(gpioOut), .gpioOeN(gpioOeN),
  .chStatus(chStatus), .settings(settings), .busIdle(busIdle));

// [verif/scsp_host_model.sv]
// Behavioural SMBus host driving clock and open-drain data
module scsp_host_model
(
  // Reference timing and wire level
  input  wire logic ref_clk,
  input  wire logic sdaWire,
  // Host drive, data high means released
  output logic      sclClk,
  output logic      sdaDrv
);
  timeunit 1ns;
  timeprecision 1ps;
  // Clock stands high and data released outside frames
  initial
  begin
    sclClk = 1'b1;
    sdaDrv = 1'b1;
  end
  // Wait some reference edges
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  // One clock pulse, data changed only while clock low
  task automatic bitIo(input logic b, output logic s);
    @(posedge ref_clk) sdaDrv <= b;
    tick(4);
    sclClk <= 1'b1;
    tick(4);
    s = sdaWire;
    tick(4);
    sclClk <= 1'b0;
    tick(3);
  endtask : bitIo
  // Start or repeated start
  task automatic startC;
    @(posedge ref_clk) sdaDrv <= 1'b1;
    tick(4);
    sclClk <= 1'b1;
    tick(8);
    sdaDrv <= 1'b0;
    tick(8);
    sclClk <= 1'b0;
    tick(3);
  endtask : startC
  // Stop, then the bus free time
  task automatic stopC;
    @(posedge ref_clk) sdaDrv <= 1'b0;
    tick(4);
    sclClk <= 1'b1;
    tick(8);
    sdaDrv <= 1'b1;
    tick(130);
  endtask : stopC
  // Send a byte MSB first, return the acknowledge bit
  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bitIo(b[i], s);
    bitIo(1'b1, ack);
  endtask : sendByte
  // Receive a byte MSB first, then answer
  task automatic recvByte(output logic [7:0] b, input logic nack);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bitIo(1'b1, s);
      b[i] = s;
    end
    bitIo(nack, s);
  endtask : recvByte
endmodule : scsp_host_model

// [verif/tb.sv]
// Self-checking bench for the SMBus configuration and status port
module tb
  import scsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TMO = 200;
  logic           ref_clk = 1'b0;
  logic           reset_n = 1'b0;
  logic           mgmtModeStrap = 1'b1;
  logic [3:0]     gpioIn = 4'h0;
  scsp_status_t   chStatus = '0;
  logic           sclClk, sdaDrv, sdaWire, sdaOut, sdaOeN, busIdle;
  logic [3:0]     gpioOut, gpioOeN;
  scsp_settings_t settings;
  logic [7:0]     shadow [NUM_REGS];
  logic [6:0]     devAdr = ADDR_BASE;
  int             n_mismatch = 0;
  int             check_count = 0;
  // Wired-AND data line with pull-up
  assign sdaWire = sdaDrv & (sdaOeN | sdaOut);
  always #20 ref_clk = ~ref_clk;
  scsp_host_model host (.ref_clk(ref_clk), .sdaWire(sdaWire),
    .sclClk(sclClk), .sdaDrv(sdaDrv));
  scsp_port #(.TIMEOUT_CYCLES(TMO)) uut (
    .ref_clk(ref_clk), .reset_n(reset_n), .sclClk(sclClk), .sdaIn(sdaWire),
    .sdaOut(sdaOut), .sdaOeN(sdaOeN), .mgmtModeStrap(mgmtModeStrap),
    .gpioIn(gpioIn), .gpioOut(gpioOut), .gpioOeN(gpioOeN),
    .chStatus(chStatus), .settings(settings), .busIdle(busIdle));
  // Compare and count
  task automatic chk(input string nm, input logic [127:0] got, exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop
  // Register write through the link
  task automatic regWr(input logic [7:0] ofs, dat);
    logic a0, a1, a2;
    host.startC();
    host.sendByte({devAdr, 1'b0}, a0);
    host.sendByte(ofs, a1);
    host.sendByte(dat, a2);
    host.stopC();
    chk("wr ack", {a0, a1, a2}, 3'h0);
  endtask : regWr
  // Register read with repeated start
  task automatic regRd(input logic [7:0] ofs, output logic [7:0] dat);
    logic a0, a1, a2;
    host.startC();
    host.sendByte({devAdr, 1'b0}, a0);
    host.sendByte(ofs, a1);
    host.startC();
    host.sendByte({devAdr, 1'b1}, a2);
    host.recvByte(dat, 1'b1);
    host.stopC();
    chk("rd ack", {a0, a1, a2}, 3'h0);
  endtask : regRd
  // Settings expected from the shadow registers
  function automatic scsp_settings_t expSet();
    scsp_settings_t s;
    for (int k = 0; k < 8; k++)
      s.swing[k] = shadow[SWING_IDX[k]];
    for (int k = 0; k < 4; k++)
    begin
      s.eq[k] = shadow[EQ_IDX[k]];
      s.deemph[k] = shadow[DEEMPH_IDX[k]];
    end
    return s;
  endfunction : expSet
  // Status pins expected from routing and detector state
  function automatic logic [3:0] expPins(input logic [7:0] ir, rr,
                                         input scsp_status_t s);
    logic [3:0] g;
    for (int k = 0; k < NUM_PINS; k++)
      g[k] = (ir[IDLE_LO_BIT] & s.idle[PIN_CH_LO[k]]) |
             (ir[IDLE_HI_BIT] & s.idle[PIN_CH_HI[k]]) |
             (rr[RATE_LO_BIT] & s.rate[PIN_CH_LO[k]]) |
             (rr[RATE_HI_BIT] & s.rate[PIN_CH_HI[k]]);
    return g;
  endfunction : expPins
  // Watchdog against a hung run
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    n_mismatch++;
    report_and_stop();
  end
  // Main sequence
  initial
  begin
    logic [7:0] d;
    logic       a;
    int         x;
    logic [7:0] rt [4][2];
    logic [3:0] sel [3];
    rt = '{'{8'h32, 8'h00}, '{8'h00, 8'hC0}, '{8'h10, 8'h40}, '{8'h30, 8'hC0}};
    void'($urandom(18));
    sel = '{4'h1, 4'h8, 4'($urandom)};
    shadow = REG_DEF;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (1300) @(posedge ref_clk);
    chk("idle", busIdle, 1'b1);
    chk("set def", settings, expSet());
    chk("sda out", sdaOut, 1'b0);
    for (int i = 0; i < NUM_REGS; i++)
    begin
      regRd(REG_OFS[i], d);
      chk("rd def", d, shadow[i]);
    end
    // Preset programming of swing, equalization, de-emphasis
    for (int k = 0; k < 8; k++)
    begin
      regWr(REG_OFS[SWING_IDX[k]], 8'h0F);
      shadow[SWING_IDX[k]] = 8'h0F;
    end
    for (int k = 0; k < 4; k++)
    begin
      regWr(REG_OFS[EQ_IDX[k]], 8'h39);
      regWr(REG_OFS[DEEMPH_IDX[k]], 8'hA0);
      shadow[EQ_IDX[k]] = 8'h39;
      shadow[DEEMPH_IDX[k]] = 8'hA0;
    end
    chk("presets", settings, expSet());
    for (int n = 0; n < 8; n++)
    begin
      x = 1 + int'($urandom % 16);
      d = 8'($urandom);
      regWr(REG_OFS[x], d);
      shadow[x] = d;
      chk("set wr", settings, expSet());
      regRd(REG_OFS[x], d);
      chk("rd back", d, shadow[x]);
    end
    regWr(OFS_RESET, RESET_CMD);
    shadow = REG_DEF;
    chk("set rst", settings, expSet());
    regRd(OFS_RESET, d);
    chk("rd rst", d, 8'h00);
    // Select inputs move the address
    for (int n = 0; n < 3; n++)
    begin
      @(posedge ref_clk) gpioIn <= sel[n];
      repeat (6) @(posedge ref_clk);
      devAdr = ADDR_BASE | {3'h0, sel[n]};
      regRd(REG_OFS[1], d);
      chk("rd sel", d, shadow[1]);
    end
    host.startC();
    host.sendByte({devAdr ^ 7'h01, 1'b0}, a);
    host.stopC();
    chk("bad adr", a, 1'b1);
    @(posedge ref_clk) mgmtModeStrap <= 1'b0;
    repeat (10) @(posedge ref_clk);
    host.startC();
    host.sendByte({devAdr, 1'b0}, a);
    host.stopC();
    chk("strap", a, 1'b1);
    @(posedge ref_clk) mgmtModeStrap <= 1'b1;
    repeat (10) @(posedge ref_clk);
    // Clock held low during acknowledge
    host.startC();
    for (int i = 7; i >= 0; i--)
      host.bitIo(i == 0 ? 1'b0 : devAdr[i - 1], a);
    repeat (10) @(posedge ref_clk);
    chk("ack on", sdaOeN, 1'b0);
    repeat (TMO + 20) @(posedge ref_clk);
    chk("tmo rel", sdaOeN, 1'b1);
    host.stopC();
    // Status pin routing
    regWr(8'h4E, 8'h01);
    chk("pin oe", gpioOeN, 4'h0);
    for (int r = 0; r < 4; r++)
    begin
      regWr(8'h47, rt[r][0]);
      regWr(8'h4C, rt[r][1]);
      for (int n = 0; n < 5; n++)
      begin
        @(posedge ref_clk) chStatus <= (n == 0) ? '0 : 16'($urandom);
        repeat (8) @(posedge ref_clk);
        chk("pins", gpioOut, expPins(rt[r][0], rt[r][1], chStatus));
      end
    end
    report_and_stop();
  end
endmodule : tb
